// ---- rtl/cogm_reg16.sv ----
// One 16-bit control register with forced default and write lock
`timescale 1ns/10ps
`default_nettype none
module cogm_reg16
	import cogm_pkg::*;
#(
	parameter logic [15:0] RST_VAL = 16'h0000
)
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic lock,
	input wire logic wr_en,
	input wire logic [31:0] wr_data,
	input wire logic [3:0] wr_strb,
	output logic [15:0] value_ff
);
	logic [15:0] nxt_value;

	always_comb
	begin
		nxt_value = value_ff;
		if (wr_en)
		begin
			if (wr_strb[0])
				nxt_value[7:0] = wr_data[7:0] & COGM_WRITABLE_MASK[7:0];
			if (wr_strb[1])
				nxt_value[15:8] = wr_data[15:8] & COGM_WRITABLE_MASK[15:8];
		end
		// Lock wins over a write in the same cycle
		if (lock)
			nxt_value = RST_VAL;
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			value_ff <= RST_VAL;
		else
			value_ff <= nxt_value;
	end
endmodule
`default_nettype wire

// ---- rtl/cogm_regs.sv ----
// Output gain and digital mix register bank with AXI4-Lite slave
//
// Functional notes
// - Output-2 analog mute bit set silences its channel, clear passes signal.
// - Output-2 gain code steps -1.5 dB; 0 is +12 dB, 8 is unity.
// - Codes below 32 analog only; top bit holds analog floor, adds digital steps.
// - Output-2 gain resets 8888h; held and locked under pins, powerdown, enables.
// - Output-1 digital attenuation -1.5 dB per count, 0 to 63.
// - Output-2 digital attenuation -1.5 dB per count, 0 to 63.
// - Digital mute bit set silences that channel's digital path.
// - Both attenuation registers reset 0000h and lock under pins or powerdown.
// - Mix into output 1 attenuates per count; code 63 fully mutes.
// - Mix mute bit set disables that mix path.
// - Left mix into output 2 scales like output-1 mix.
// - Mix-1 register resets 8080h and locks under pins or powerdown.
// - Timing bit clear: gain applies at zero cross or timeout; set: immediately.
// - Mix-2 register resets 8080h, same lock as mix-1.
`timescale 1ns/10ps
`default_nettype none
module cogm_regs
	import cogm_pkg::*;
#(
	parameter int TIMEOUT_CYC = COGM_TIMEOUT_CYC
)
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic reset_pin_n,
	input wire logic powerdown_pin_n,
	input wire logic left_out2_zero_cross,
	input wire logic right_out2_zero_cross,
	input wire logic [COGM_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [COGM_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output cogm_out2_chan_t left_out2_applied_ff,
	output cogm_out2_chan_t right_out2_applied_ff,
	output logic left_out1_digital_mute_ff,
	output logic right_out1_digital_mute_ff,
	output logic [5:0] left_out1_digital_level_ff,
	output logic [5:0] right_out1_digital_level_ff,
	output logic left_out2_digital_mute_ff,
	output logic right_out2_digital_mute_ff,
	output logic [5:0] left_out2_digital_level_ff,
	output logic [5:0] right_out2_digital_level_ff,
	output logic left_sidetone1_enable_ff,
	output logic right_sidetone1_enable_ff,
	output logic [5:0] left_sidetone1_level_ff,
	output logic [5:0] right_sidetone1_level_ff,
	output logic left_sidetone2_enable_ff,
	output logic right_sidetone2_enable_ff,
	output logic [5:0] left_sidetone2_level_ff,
	output logic [5:0] right_sidetone2_level_ff
);
	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [2:0] rstpin_sync_ff;
	logic [2:0] pdpin_sync_ff;
	logic [2:0] lzc_sync_ff;
	logic [2:0] rzc_sync_ff;
	logic rstpin_low_ff;
	logic pdpin_low_ff;

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rstpin_sync_ff <= 3'h0;
			pdpin_sync_ff <= 3'h0;
			lzc_sync_ff <= 3'h0;
			rzc_sync_ff <= 3'h0;
		end
		else
		begin
			rstpin_sync_ff <= {rstpin_sync_ff[1:0], reset_pin_n};
			pdpin_sync_ff <= {pdpin_sync_ff[1:0], powerdown_pin_n};
			lzc_sync_ff <= {lzc_sync_ff[1:0], left_out2_zero_cross};
			rzc_sync_ff <= {rzc_sync_ff[1:0], right_out2_zero_cross};
		end
	end

	// A level change counts once stages two and three agree
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rstpin_low_ff <= 1'b1;
			pdpin_low_ff <= 1'b1;
		end
		else
		begin
			if (rstpin_sync_ff[2] == rstpin_sync_ff[1])
				rstpin_low_ff <= ~rstpin_sync_ff[2];
			if (pdpin_sync_ff[2] == pdpin_sync_ff[1])
				pdpin_low_ff <= ~pdpin_sync_ff[2];
		end
	end

	logic zc_left;
	logic zc_right;
	assign zc_left = lzc_sync_ff[2] & lzc_sync_ff[1];
	assign zc_right = rzc_sync_ff[2] & rzc_sync_ff[1];

	// ----------------------------------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------------------------------
	logic [COGM_ADDR_W-1:0] awaddr_ff;
	logic [31:0] wdata_ff;
	logic [3:0] wstrb_ff;
	logic aw_held_ff;
	logic w_held_ff;
	logic wr_fire;
	logic [3:0] wr_idx;
	logic [3:0] rd_idx;
	logic wr_aligned;
	logic rd_aligned;

	assign wr_fire = aw_held_ff & w_held_ff & ~s_axi_bvalid;
	assign wr_idx = awaddr_ff[COGM_BYTE_SHIFT +: 4];
	assign wr_aligned = (awaddr_ff[COGM_BYTE_SHIFT-1:0] == 2'h0) &&
		(awaddr_ff[COGM_ADDR_W-1:COGM_BYTE_SHIFT+4] == 2'h0);
	assign rd_idx = s_axi_araddr[COGM_BYTE_SHIFT +: 4];
	assign rd_aligned = (s_axi_araddr[COGM_BYTE_SHIFT-1:0] == 2'h0) &&
		(s_axi_araddr[COGM_ADDR_W-1:COGM_BYTE_SHIFT+4] == 2'h0);

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			aw_held_ff <= 1'b0;
			w_held_ff <= 1'b0;
			awaddr_ff <= '0;
			wdata_ff <= 32'h0000_0000;
			wstrb_ff <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= COGM_RESP_OKAY;
		end
		else
		begin
			s_axi_awready <= ~aw_held_ff & ~(s_axi_awvalid & s_axi_awready);
			s_axi_wready <= ~w_held_ff & ~(s_axi_wvalid & s_axi_wready);
			if (s_axi_awvalid & s_axi_awready)
			begin
				aw_held_ff <= 1'b1;
				awaddr_ff <= s_axi_awaddr;
			end
			if (s_axi_wvalid & s_axi_wready)
			begin
				w_held_ff <= 1'b1;
				wdata_ff <= s_axi_wdata;
				wstrb_ff <= s_axi_wstrb;
			end
			if (wr_fire)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (wr_aligned && (wr_idx >= COGM_IDX_DAC2_ANALOG_GAIN))
					? COGM_RESP_OKAY : COGM_RESP_SLVERR;
			end
			if (s_axi_bvalid & s_axi_bready)
			begin
				s_axi_bvalid <= 1'b0;
				aw_held_ff <= 1'b0;
				w_held_ff <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Power control and lock conditions
	// ----------------------------------------------------------------
	logic [3:0] power_ctrl_ff;
	logic lock_common;
	logic lock_analog;

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			power_ctrl_ff <= COGM_RST_POWER_CTRL;
		else if (wr_fire && wr_aligned && wr_idx == COGM_IDX_POWER_CTRL && wstrb_ff[0])
			power_ctrl_ff <= wdata_ff[3:0];
	end

	assign lock_common = rstpin_low_ff | pdpin_low_ff | power_ctrl_ff[COGM_PC_GLOBAL_PD];
	assign lock_analog = lock_common | ~power_ctrl_ff[COGM_PC_ANALOG_EN] |
		~power_ctrl_ff[COGM_PC_OUT2_EN];

	// ----------------------------------------------------------------
	// Register file
	// ----------------------------------------------------------------
	localparam int NREG = 5;
	localparam logic [NREG*16-1:0] RST_VALS = {COGM_RST_MIX, COGM_RST_MIX,
		COGM_RST_DIGITAL_ATTEN, COGM_RST_DIGITAL_ATTEN, COGM_RST_ANALOG_GAIN};
	logic [15:0] reg_val [NREG];

	genvar gi;
	generate
		for (gi = 0; gi < NREG; gi++)
		begin : g_reg
			cogm_reg16 #(
				.RST_VAL(RST_VALS[gi*16 +: 16])
			) u_reg (
				.ref_clk(ref_clk),
				.rst_n(rst_n),
				.lock((gi == 0) ? lock_analog : lock_common),
				.wr_en(wr_fire && wr_aligned &&
					wr_idx == 4'(COGM_IDX_DAC2_ANALOG_GAIN + gi)),
				.wr_data(wdata_ff),
				.wr_strb(wstrb_ff),
				.value_ff(reg_val[gi])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// Read channel
	// ----------------------------------------------------------------
	logic [31:0] nxt_rdata;
	logic out2_pending_ff;

	always_comb
	begin
		nxt_rdata = 32'h0000_0000;
		if (rd_idx >= COGM_IDX_DAC2_ANALOG_GAIN && rd_idx < COGM_IDX_POWER_CTRL)
			nxt_rdata[15:0] = reg_val[3'(rd_idx - COGM_IDX_DAC2_ANALOG_GAIN)];
		else if (rd_idx == COGM_IDX_POWER_CTRL)
			nxt_rdata[3:0] = power_ctrl_ff;
		else if (rd_idx == COGM_IDX_STATUS)
			nxt_rdata[4:0] = {out2_pending_ff, lock_analog, lock_common,
				pdpin_low_ff, rstpin_low_ff};
	end


	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= COGM_RESP_OKAY;
		end
		else
		begin
			s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
			if (s_axi_arvalid & s_axi_arready)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_aligned ? nxt_rdata : 32'h0000_0000;
				s_axi_rresp <= rd_aligned ? COGM_RESP_OKAY : COGM_RESP_SLVERR;
			end
			else if (s_axi_rvalid & s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Output-2 gain decode and change timing
	// ----------------------------------------------------------------
	function automatic cogm_out2_chan_t cogm_decode(input logic mute, input logic [5:0] code);
		cogm_out2_chan_t c;
		c.mute = mute;
		// Upper half holds analog floor and adds digital steps
		if (code[COGM_ANALOG_TOP_BIT])
		begin
			c.analog_step = COGM_ANALOG_FLOOR;
			c.digital_step = {1'b0, code[4:0]} + 6'h01;
		end
		else
		begin
			c.analog_step = code[4:0];
			c.digital_step = 6'h00;
		end
		return c;
	endfunction

	// Code 63 needs 32 digital steps, so the step field is six bits wide
	cogm_out2_chan_t want_l;
	cogm_out2_chan_t want_r;
	assign want_l = cogm_decode(reg_val[0][COGM_LEFT_MUTE_BIT],
		reg_val[0][COGM_LEFT_LVL_LSB +: COGM_LVL_W]);
	assign want_r = cogm_decode(reg_val[0][COGM_RIGHT_MUTE_BIT],
		reg_val[0][COGM_RIGHT_LVL_LSB +: COGM_LVL_W]);

	logic [$clog2(TIMEOUT_CYC+1)-1:0] tmo_cnt_ff;
	logic tmo_hit;
	logic immediate;
	assign immediate = power_ctrl_ff[COGM_PC_OUT2_TIMING];
	assign tmo_hit = (tmo_cnt_ff == ($clog2(TIMEOUT_CYC+1))'(TIMEOUT_CYC));

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			left_out2_applied_ff <= cogm_decode(COGM_RST_ANALOG_GAIN[COGM_LEFT_MUTE_BIT],
				COGM_RST_ANALOG_GAIN[COGM_LEFT_LVL_LSB +: COGM_LVL_W]);
			right_out2_applied_ff <= cogm_decode(COGM_RST_ANALOG_GAIN[COGM_RIGHT_MUTE_BIT],
				COGM_RST_ANALOG_GAIN[COGM_RIGHT_LVL_LSB +: COGM_LVL_W]);
			tmo_cnt_ff <= '0;
			out2_pending_ff <= 1'b0;
		end
		else
		begin
			out2_pending_ff <= (left_out2_applied_ff != want_l) ||
				(right_out2_applied_ff != want_r);
			// Delayed change avoids audible clicks
			if (immediate || zc_left || tmo_hit)
				left_out2_applied_ff <= want_l;
			if (immediate || zc_right || tmo_hit)
				right_out2_applied_ff <= want_r;
			if (!out2_pending_ff || tmo_hit)
				tmo_cnt_ff <= '0;
			else
				tmo_cnt_ff <= tmo_cnt_ff + 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Digital attenuation and mix outputs
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			left_out1_digital_mute_ff <= 1'b0;
			right_out1_digital_mute_ff <= 1'b0;
			left_out1_digital_level_ff <= 6'h00;
			right_out1_digital_level_ff <= 6'h00;
			left_out2_digital_mute_ff <= 1'b0;
			right_out2_digital_mute_ff <= 1'b0;
			left_out2_digital_level_ff <= 6'h00;
			right_out2_digital_level_ff <= 6'h00;
		end
		else
		begin
			left_out1_digital_mute_ff <= reg_val[1][COGM_LEFT_MUTE_BIT];
			right_out1_digital_mute_ff <= reg_val[1][COGM_RIGHT_MUTE_BIT];
			left_out1_digital_level_ff <= reg_val[1][COGM_LEFT_LVL_LSB +: COGM_LVL_W];
			right_out1_digital_level_ff <= reg_val[1][COGM_RIGHT_LVL_LSB +: COGM_LVL_W];
			left_out2_digital_mute_ff <= reg_val[2][COGM_LEFT_MUTE_BIT];
			right_out2_digital_mute_ff <= reg_val[2][COGM_RIGHT_MUTE_BIT];
			left_out2_digital_level_ff <= reg_val[2][COGM_LEFT_LVL_LSB +: COGM_LVL_W];
			right_out2_digital_level_ff <= reg_val[2][COGM_RIGHT_LVL_LSB +: COGM_LVL_W];
		end
	end

	// Level code 63 mutes the mix as fully as the mute bit
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			left_sidetone1_enable_ff <= 1'b0;
			right_sidetone1_enable_ff <= 1'b0;
			left_sidetone1_level_ff <= 6'h00;
			right_sidetone1_level_ff <= 6'h00;
			left_sidetone2_enable_ff <= 1'b0;
			right_sidetone2_enable_ff <= 1'b0;
			left_sidetone2_level_ff <= 6'h00;
			right_sidetone2_level_ff <= 6'h00;
		end
		else
		begin
			left_sidetone1_enable_ff <= ~reg_val[3][COGM_LEFT_MUTE_BIT] &&
				reg_val[3][COGM_LEFT_LVL_LSB +: COGM_LVL_W] != COGM_LVL_FULL_MUTE;
			right_sidetone1_enable_ff <= ~reg_val[3][COGM_RIGHT_MUTE_BIT] &&
				reg_val[3][COGM_RIGHT_LVL_LSB +: COGM_LVL_W] != COGM_LVL_FULL_MUTE;
			left_sidetone1_level_ff <= reg_val[3][COGM_LEFT_LVL_LSB +: COGM_LVL_W];
			right_sidetone1_level_ff <= reg_val[3][COGM_RIGHT_LVL_LSB +: COGM_LVL_W];
			left_sidetone2_enable_ff <= ~reg_val[4][COGM_LEFT_MUTE_BIT] &&
				reg_val[4][COGM_LEFT_LVL_LSB +: COGM_LVL_W] != COGM_LVL_FULL_MUTE;
			right_sidetone2_enable_ff <= ~reg_val[4][COGM_RIGHT_MUTE_BIT] &&
				reg_val[4][COGM_RIGHT_LVL_LSB +: COGM_LVL_W] != COGM_LVL_FULL_MUTE;
			left_sidetone2_level_ff <= reg_val[4][COGM_LEFT_LVL_LSB +: COGM_LVL_W];
			right_sidetone2_level_ff <= reg_val[4][COGM_RIGHT_LVL_LSB +: COGM_LVL_W];
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	property p_gain_locked;
		@(posedge ref_clk) disable iff (!rst_n)
		lock_analog |=> (reg_val[0] == COGM_RST_ANALOG_GAIN);
	endproperty
	a_gain_locked: assert property (p_gain_locked) else $error("gain not held at default");

	property p_atten_locked;
		@(posedge ref_clk) disable iff (!rst_n)
		lock_common |=> (reg_val[1] == COGM_RST_DIGITAL_ATTEN && reg_val[2] == COGM_RST_DIGITAL_ATTEN);
	endproperty
	a_atten_locked: assert property (p_atten_locked) else $error("attenuation not held");

	property p_mix1_locked;
		@(posedge ref_clk) disable iff (!rst_n)
		lock_common |=> (reg_val[3] == COGM_RST_MIX);
	endproperty
	a_mix1_locked: assert property (p_mix1_locked) else $error("mix1 not held");

	property p_mix2_locked;
		@(posedge ref_clk) disable iff (!rst_n)
		lock_common |=> (reg_val[4] == COGM_RST_MIX);
	endproperty
	a_mix2_locked: assert property (p_mix2_locked) else $error("mix2 not held");

	property p_immediate;
		@(posedge ref_clk) disable iff (!rst_n)
		(immediate && $stable(reg_val[0])) |=> (left_out2_applied_ff == $past(want_l));
	endproperty
	a_immediate: assert property (p_immediate) else $error("immediate gain not applied");

	property p_delay_hold;
		@(posedge ref_clk) disable iff (!rst_n)
		(!immediate && !zc_left && !tmo_hit) |=> $stable(left_out2_applied_ff);
	endproperty
	a_delay_hold: assert property (p_delay_hold) else $error("gain changed early");

	property p_mix_fullmute;
		@(posedge ref_clk) disable iff (!rst_n)
		(reg_val[3][COGM_LEFT_LVL_LSB +: COGM_LVL_W] == COGM_LVL_FULL_MUTE) |=> !left_sidetone1_enable_ff;
	endproperty
	a_mix_fullmute: assert property (p_mix_fullmute) else $error("mix not muted at 63");

	property p_dmute;
		@(posedge ref_clk) disable iff (!rst_n)
		reg_val[1][COGM_LEFT_MUTE_BIT] |=> left_out1_digital_mute_ff;
	endproperty
	a_dmute: assert property (p_dmute) else $error("digital mute lost");
endmodule
`default_nettype wire

// ---- shared/cogm_pkg.sv ----
// Package: register map, field layout, reset values and timing constants of the gain and mix bank
package cogm_pkg;
	// Register indices; byte address is four times the index
	localparam logic [3:0] COGM_IDX_DAC2_ANALOG_GAIN = 4'hA;
	localparam logic [3:0] COGM_IDX_DAC1_DIGITAL_ATTEN = 4'hB;
	localparam logic [3:0] COGM_IDX_DAC2_DIGITAL_ATTEN = 4'hC;
	localparam logic [3:0] COGM_IDX_ADC_TO_DAC1_MIX = 4'hD;
	localparam logic [3:0] COGM_IDX_ADC_TO_DAC2_MIX = 4'hE;
	localparam logic [3:0] COGM_IDX_POWER_CTRL = 4'hF;
	localparam logic [3:0] COGM_IDX_STATUS = 4'h0;
	localparam int COGM_ADDR_W = 8;
	localparam int COGM_BYTE_SHIFT = 2;
	// Field layout of every 16-bit register
	localparam int COGM_LEFT_MUTE_BIT = 15;
	localparam int COGM_LEFT_LVL_LSB = 8;
	localparam int COGM_RIGHT_MUTE_BIT = 7;
	localparam int COGM_RIGHT_LVL_LSB = 0;
	localparam int COGM_LVL_W = 6;
	localparam logic [15:0] COGM_WRITABLE_MASK = 16'hBFBF;
	// Reset values
	localparam logic [15:0] COGM_RST_ANALOG_GAIN = 16'h8888;
	localparam logic [15:0] COGM_RST_DIGITAL_ATTEN = 16'h0000;
	localparam logic [15:0] COGM_RST_MIX = 16'h8080;
	// Gain code meaning
	localparam logic [5:0] COGM_LVL_FULL_MUTE = 6'h3F;
	localparam int COGM_ANALOG_TOP_BIT = 5;
	localparam logic [4:0] COGM_ANALOG_FLOOR = 5'h1F;
	// Power control bit positions (own register)
	localparam int COGM_PC_GLOBAL_PD = 0;
	localparam int COGM_PC_ANALOG_EN = 1;
	localparam int COGM_PC_OUT2_EN = 2;
	localparam int COGM_PC_OUT2_TIMING = 3;
	localparam logic [3:0] COGM_RST_POWER_CTRL = 4'h1;
	// Zero-cross timeout: 10 ms least
	localparam int COGM_TIMEOUT_MS = 10;
	localparam int COGM_CLK_MHZ = 200;
	localparam int COGM_TIMEOUT_CYC = COGM_TIMEOUT_MS * 1000 * COGM_CLK_MHZ;
	localparam logic [1:0] COGM_RESP_OKAY = 2'h0;
	localparam logic [1:0] COGM_RESP_SLVERR = 2'h2;
	// Applied level of one output-2 channel
	typedef struct packed {
		logic mute;
		logic [4:0] analog_step;
		logic [5:0] digital_step;
	} cogm_out2_chan_t;
endpackage

// ---- test/cogm_regs_tb.sv ----
// Self-checking bench for the output gain and digital mix register bank
`timescale 1ns/10ps
`default_nettype none
module cogm_regs_tb
	import cogm_pkg::*;
;
// --------------------------------------------------
// Addresses, signals and design
// --------------------------------------------------
localparam logic [7:0] A_GAIN = {2'h0, COGM_IDX_DAC2_ANALOG_GAIN, 2'h0};
localparam logic [7:0] A_ATT1 = {2'h0, COGM_IDX_DAC1_DIGITAL_ATTEN, 2'h0};
localparam logic [7:0] A_ATT2 = {2'h0, COGM_IDX_DAC2_DIGITAL_ATTEN, 2'h0};
localparam logic [7:0] A_MIX1 = {2'h0, COGM_IDX_ADC_TO_DAC1_MIX, 2'h0};
localparam logic [7:0] A_MIX2 = {2'h0, COGM_IDX_ADC_TO_DAC2_MIX, 2'h0};
localparam logic [7:0] A_PWR = {2'h0, COGM_IDX_POWER_CTRL, 2'h0};
localparam logic [7:0] A_STAT = {2'h0, COGM_IDX_STATUS, 2'h0};
localparam logic [1:0] OK = COGM_RESP_OKAY;
localparam logic [1:0] ERR = COGM_RESP_SLVERR;
logic ref_clk, rst_n, reset_pin_n, powerdown_pin_n, left_out2_zero_cross, right_out2_zero_cross;
logic [COGM_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
logic [31:0] s_axi_wdata, s_axi_rdata;
logic [3:0] s_axi_wstrb;
logic [1:0] s_axi_bresp, s_axi_rresp;
logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
cogm_out2_chan_t left_out2_applied_ff, right_out2_applied_ff;
logic left_out1_digital_mute_ff, right_out1_digital_mute_ff;
logic left_out2_digital_mute_ff, right_out2_digital_mute_ff;
logic [5:0] left_out1_digital_level_ff, right_out1_digital_level_ff;
logic [5:0] left_out2_digital_level_ff, right_out2_digital_level_ff;
logic left_sidetone1_enable_ff, right_sidetone1_enable_ff;
logic left_sidetone2_enable_ff, right_sidetone2_enable_ff;
logic [5:0] left_sidetone1_level_ff, right_sidetone1_level_ff;
logic [5:0] left_sidetone2_level_ff, right_sidetone2_level_ff;
int num_errors;
int checks;

// Short timeout keeps the deferred gain case to a few dozen cycles
cogm_regs #(.TIMEOUT_CYC(20)) i_cogm_regs (
	.ref_clk, .rst_n, .reset_pin_n, .powerdown_pin_n, .left_out2_zero_cross,
	.right_out2_zero_cross, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
	.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
	.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
	.s_axi_rready, .left_out2_applied_ff, .right_out2_applied_ff, .left_out1_digital_mute_ff,
	.right_out1_digital_mute_ff, .left_out1_digital_level_ff, .right_out1_digital_level_ff,
	.left_out2_digital_mute_ff, .right_out2_digital_mute_ff, .left_out2_digital_level_ff,
	.right_out2_digital_level_ff, .left_sidetone1_enable_ff, .right_sidetone1_enable_ff,
	.left_sidetone1_level_ff, .right_sidetone1_level_ff, .left_sidetone2_enable_ff,
	.right_sidetone2_enable_ff, .left_sidetone2_level_ff, .right_sidetone2_level_ff
);

// --------------------------------------------------
// Tasks
// --------------------------------------------------
task automatic stop_test();
	$display("Comparisons %0d, mismatches %0d", checks, num_errors);
	if (num_errors == 0 && checks > 0)
	begin
		$display("All tests passed");
	end
	else
	begin
		$display("Some tests failed");
	end
	$finish;
endtask

task automatic check(input logic [31:0] seen, input logic [31:0] exp);
	checks++;
	if (seen !== exp)
	begin
		num_errors++;
		$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
	end
endtask

task automatic expired();
	num_errors++;
	$display("[ERR] %0t wait limit used up", $time);
	stop_test();
endtask

// Address and data are offered together; each is dropped once taken
task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
	int n;
	logic aw_ok;
	logic w_ok;
	aw_ok = 1'b0;
	w_ok = 1'b0;
	s_axi_awaddr <= a;
	s_axi_wdata <= d;
	s_axi_awvalid <= 1'b1;
	s_axi_wvalid <= 1'b1;
	s_axi_bready <= 1'b1;
	for (n = 0; n < 50; n++)
	begin
		@(posedge ref_clk);
		if (!aw_ok && s_axi_awready === 1'b1)
		begin
			aw_ok = 1'b1;
			s_axi_awvalid <= 1'b0;
		end
		if (!w_ok && s_axi_wready === 1'b1)
		begin
			w_ok = 1'b1;
			s_axi_wvalid <= 1'b0;
		end
		if (s_axi_bvalid === 1'b1)
		begin
			s_axi_bready <= 1'b0;
			check({30'h0, s_axi_bresp}, {30'h0, er});
			@(posedge ref_clk);
			return;
		end
	end
	expired();
endtask

task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
	int n;
	s_axi_araddr <= a;
	s_axi_arvalid <= 1'b1;
	s_axi_rready <= 1'b1;
	for (n = 0; n < 50; n++)
	begin
		@(posedge ref_clk);
		if (s_axi_arready === 1'b1)
		begin
			s_axi_arvalid <= 1'b0;
		end
		if (s_axi_rvalid === 1'b1)
		begin
			s_axi_rready <= 1'b0;
			check(s_axi_rdata, ed);
			check({30'h0, s_axi_rresp}, {30'h0, er});
			@(posedge ref_clk);
			return;
		end
	end
	expired();
endtask

// Waits a bounded time for both applied output-2 settings, then compares
task automatic wait_app(input logic [11:0] l, input logic [11:0] r, input int lim);
	int n;
	n = 0;
	while ((left_out2_applied_ff !== l || right_out2_applied_ff !== r) && n < lim)
	begin
		@(posedge ref_clk);
		n++;
	end
	check({20'h0, left_out2_applied_ff}, {20'h0, l});
	check({20'h0, right_out2_applied_ff}, {20'h0, r});
endtask

// --------------------------------------------------
// Clock and test sequence
// --------------------------------------------------
initial
begin
	ref_clk = 1'b0;
	forever #2.5 ref_clk = ~ref_clk;
end

initial
begin
	num_errors = 0;
	checks = 0;
	rst_n = 1'b0;
	reset_pin_n = 1'b1;
	powerdown_pin_n = 1'b1;
	left_out2_zero_cross = 1'b0;
	right_out2_zero_cross = 1'b0;
	s_axi_awaddr = 8'h00;
	s_axi_araddr = 8'h00;
	s_axi_wdata = 32'h0;
	s_axi_wstrb = 4'hF;
	{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
	repeat (4) @(posedge ref_clk);
	rst_n <= 1'b1;
	repeat (6) @(posedge ref_clk);
	check({20'h0, left_out2_applied_ff}, {20'h0, 1'b1, 5'h08, 6'h00});
	axi_rd(A_GAIN, 32'h8888, OK);
	axi_rd(A_ATT1, 32'h0000, OK);
	axi_rd(A_ATT2, 32'h0000, OK);
	axi_rd(A_MIX1, 32'h8080, OK);
	axi_rd(A_MIX2, 32'h8080, OK);
	axi_rd(A_PWR, 32'h0001, OK);
	// Global conversion powerdown is set out of reset
	axi_wr(A_ATT1, 32'h3F81, OK);
	axi_rd(A_ATT1, 32'h0000, OK);
	axi_wr(A_MIX2, 32'h0A00, OK);
	axi_rd(A_MIX2, 32'h8080, OK);
	axi_wr(A_PWR, 32'h0000, OK);
	axi_wr(A_GAIN, 32'h0820, OK);
	axi_rd(A_GAIN, 32'h8888, OK);
	axi_wr(A_ATT1, 32'h3F81, OK);
	axi_rd(A_ATT1, 32'h3F81, OK);
	check({18'h0, left_out1_digital_mute_ff, left_out1_digital_level_ff, right_out1_digital_mute_ff, right_out1_digital_level_ff}, {18'h0, 1'b0, 6'h3F, 1'b1, 6'h01});
	axi_wr(A_ATT2, 32'h803F, OK);
	axi_rd(A_ATT2, 32'h803F, OK);
	check({18'h0, left_out2_digital_mute_ff, left_out2_digital_level_ff, right_out2_digital_mute_ff, right_out2_digital_level_ff}, {18'h0, 1'b1, 6'h00, 1'b0, 6'h3F});
	axi_wr(A_MIX1, 32'h3EBF, OK);
	axi_rd(A_MIX1, 32'h3EBF, OK);
	check({18'h0, left_sidetone1_enable_ff, left_sidetone1_level_ff, right_sidetone1_enable_ff, right_sidetone1_level_ff}, {18'h0, 1'b1, 6'h3E, 1'b0, 6'h3F});
	axi_wr(A_MIX1, 32'h3F05, OK);
	axi_rd(A_MIX1, 32'h3F05, OK);
	check({18'h0, left_sidetone1_enable_ff, left_sidetone1_level_ff, right_sidetone1_enable_ff, right_sidetone1_level_ff}, {18'h0, 1'b0, 6'h3F, 1'b1, 6'h05});
	axi_wr(A_MIX2, 32'h0A80, OK);
	axi_rd(A_MIX2, 32'h0A80, OK);
	check({18'h0, left_sidetone2_enable_ff, left_sidetone2_level_ff, right_sidetone2_enable_ff, right_sidetone2_level_ff}, {18'h0, 1'b1, 6'h0A, 1'b0, 6'h00});
	// Output-2 gain with immediate timing
	axi_wr(A_PWR, 32'h000E, OK);
	axi_wr(A_GAIN, 32'h0820, OK);
	axi_rd(A_GAIN, 32'h0820, OK);
	wait_app({1'b0, 5'h08, 6'h00}, {1'b0, 5'h1F, 6'h01}, 10);
	axi_wr(A_GAIN, 32'h9F3F, OK);
	wait_app({1'b1, 5'h1F, 6'h00}, {1'b0, 5'h1F, 6'h20}, 10);
	axi_wr(A_GAIN, 32'h0028, OK);
	wait_app({1'b0, 5'h00, 6'h00}, {1'b0, 5'h1F, 6'h09}, 10);
	// Deferred timing: zero crossing, then timeout
	axi_wr(A_PWR, 32'h0006, OK);
	axi_wr(A_GAIN, 32'h0505, OK);
	check({20'h0, left_out2_applied_ff}, {20'h0, 1'b0, 5'h00, 6'h00});
	left_out2_zero_cross <= 1'b1;
	right_out2_zero_cross <= 1'b1;
	wait_app({1'b0, 5'h05, 6'h00}, {1'b0, 5'h05, 6'h00}, 8);
	left_out2_zero_cross <= 1'b0;
	right_out2_zero_cross <= 1'b0;
	repeat (6) @(posedge ref_clk);
	axi_wr(A_GAIN, 32'h0707, OK);
	repeat (8) @(posedge ref_clk);
	check({20'h0, left_out2_applied_ff}, {20'h0, 1'b0, 5'h05, 6'h00});
	wait_app({1'b0, 5'h07, 6'h00}, {1'b0, 5'h07, 6'h00}, 40);
	// Output-2 converter disabled forces the gain default
	axi_wr(A_PWR, 32'h0002, OK);
	axi_rd(A_GAIN, 32'h8888, OK);
	// Bus errors
	axi_rd(8'h40, 32'h0000, ERR);
	axi_wr(A_STAT, 32'h0001, ERR);
	axi_wr(8'h29, 32'h0001, ERR);
	// Pin and global powerdown locks
	powerdown_pin_n <= 1'b0;
	repeat (6) @(posedge ref_clk);
	axi_rd(A_ATT1, 32'h0000, OK);
	axi_wr(A_MIX1, 32'h0101, OK);
	axi_rd(A_MIX1, 32'h8080, OK);
	powerdown_pin_n <= 1'b1;
	repeat (6) @(posedge ref_clk);
	axi_wr(A_PWR, 32'h0000, OK);
	axi_wr(A_ATT2, 32'h0101, OK);
	axi_wr(A_MIX2, 32'h0101, OK);
	axi_rd(A_ATT2, 32'h0101, OK);
	reset_pin_n <= 1'b0;
	repeat (6) @(posedge ref_clk);
	axi_rd(A_ATT2, 32'h0000, OK);
	reset_pin_n <= 1'b1;
	repeat (6) @(posedge ref_clk);
	axi_wr(A_PWR, 32'h0000, OK);
	axi_wr(A_MIX2, 32'h0202, OK);
	axi_wr(A_PWR, 32'h0001, OK);
	axi_rd(A_MIX2, 32'h8080, OK);
	stop_test();
end
endmodule
`default_nettype wire
